// ### hw/itc_pkg.sv
// Contract
// - an initial count of zero runs 65536 binary (10000 decimal) counts in modes 0 to 4; mode 5 does not count.
// - mode 0 output drops low on control write, stays low until zero.
// - mode 0 gate high counts, gate low suspends, output untouched by gate.
// - mode 0 count loads on next count tick without decrement; high after N+1.
// - mode 0 first of two bytes suspends counting, output low; second loads next tick.
// - mode 0 count written with gate low still loads; N ticks after gate rises.
// - mode 1 output high on control write, low from trigger load for N ticks.
// - mode 1 gate falling ignored; new gate rise retriggers from holding register.
// - mode 1 count written during a pulse only takes effect at next trigger.
// - mode 2 output low one tick when count reaches one, reloads every N ticks.
// - mode 2 gate low stops counting, forces output high; rise reloads next tick.
// - mode 2 count loads next tick; low pulse N ticks after writing N.
// - mode 2 new count waits for period end, or loads after a gate trigger.
// - mode 3 output high first half, low second half; period N ticks.
// - mode 3 gate low halts, forces output high; rise reloads next tick.
// - mode 3 new count waits for half-cycle end, or loads after a gate trigger.
// - mode 3 even count loads as written, then steps down by two each tick.
// - mode 3 odd count loads N-1; falls at zero, rises at two, reloading.
// - mode 4 output high; one-tick low strobe when count reaches zero.
// - mode 4 gate enables counting only; load tick without decrement; strobe N+1.
// - mode 4 first byte harmless; second byte reloads next tick, retriggering.
// - count type bit zero counts binary, one counts four decimal digits.
// - mode field x10 and x11 give modes 2 and 3; 100, 101 give 4, 5.
package itc_pkg;
   localparam int           CNT_W       = 16;
   localparam int           CW_W        = 6;
   localparam int           ADDR_MIN_W  = 4;
   localparam logic [3:0]   CTRL_OFS    = 4'h0;
   localparam logic [3:0]   COUNT_OFS   = 4'h4;
   localparam logic [3:0]   STATUS_OFS  = 4'h8;
   localparam int           CW_BCD_BIT  = 0;
   localparam int           CW_MODE_LSB = 1;
   localparam int           CW_RL_LSB   = 4;
   localparam logic [1:0]   RL_LATCH    = 2'h0;
   localparam logic [1:0]   RL_LOW      = 2'h1;
   localparam logic [1:0]   RL_HIGH     = 2'h2;
   localparam logic [1:0]   RL_BOTH     = 2'h3;
   localparam int           ST_OUT_BIT  = 0;
   localparam int           ST_NULL_BIT = 1;
   localparam int           ST_MSBW_BIT = 2;
   localparam int           ST_GATE_BIT = 3;
   localparam int           ST_RUN_BIT  = 4;
   localparam logic [CW_W-1:0]  CW_RESET = 6'h00;
   localparam logic [CNT_W-1:0] CE_ZERO  = 16'h0000;
   localparam logic [CNT_W-1:0] CE_ONE   = 16'h0001;
   localparam logic [CNT_W-1:0] CE_TWO   = 16'h0002;
   localparam logic             OUT_RESET = 1'b0;

   typedef enum logic [2:0] {
      MODE_TERM, MODE_ONESHOT, MODE_RATE, MODE_SQUARE, MODE_SWSTB, MODE_HWSTB
   } itc_mode_type;

   typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_RUN, PH_DONE} itc_phase_type;

   function automatic itc_mode_type itc_decode_mode(input logic [2:0] m);
      if (m[1])
         return m[0] ? MODE_SQUARE : MODE_RATE;
      else if (m[2])
         return m[0] ? MODE_HWSTB : MODE_SWSTB;
      else
         return m[0] ? MODE_ONESHOT : MODE_TERM;
   endfunction

   function automatic logic [CNT_W-1:0] itc_dec1(input logic [CNT_W-1:0] v,
                                                 input logic             bcd);
      logic [CNT_W-1:0] r;
      logic             borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - CE_ONE;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               if (v[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction
endpackage

// ### hw/itc_reg_if.sv
`timescale 1ns/100ps
interface itc_reg_if;
   import itc_pkg::*;
   logic                ctrl_wr;
   logic                count_wr;
   logic [7:0]          wdata;
   logic [CW_W-1:0]     ctrl_word;
   logic [CNT_W-1:0]    ce_value;
   logic [7:0]          status;

   modport regs (output ctrl_wr, output count_wr, output wdata,
                 input ctrl_word, input ce_value, input status);
   modport core (input ctrl_wr, input count_wr, input wdata,
                 output ctrl_word, output ce_value, output status);
endinterface

// ### hw/itc_avalon_regs.sv
`timescale 1ns/100ps
module itc_avalon_regs
   import itc_pkg::*;
#(
   parameter int AW = 4
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic [AW-1:0] avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output      logic [31:0]   avs_readdata,
   output      logic          avs_waitrequest,
   itc_reg_if.regs            bus
);
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic write_go;
   logic [2:0] sel;

   // one-hot select: ctrl, count, status
   function automatic logic [2:0] reg_sel(input logic [AW-1:0] a);
      logic [3:0] low;
      low = a[3:0];
      return {low == STATUS_OFS, low == COUNT_OFS, low == CTRL_OFS}
             & {3{(a >> 4) == '0}};
   endfunction

   generate
      if (AW < ADDR_MIN_W) begin : g_bad_aw
         $error("address width too small for register map");
      end
   endgenerate

   // every request is held one cycle, answered on the next
   always_ff @(posedge clk) begin
      if (srst)
         waitrequest_reg <= 1'b1;
      else
         waitrequest_reg <= ~((avs_read | avs_write) & waitrequest_reg);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (avs_read && waitrequest_reg) begin
         unique case (reg_sel(avs_address))
            3'b001:  readdata_reg <= {26'h000_0000, bus.ctrl_word};
            3'b010:  readdata_reg <= {16'h0000, bus.ce_value};
            3'b100:  readdata_reg <= {24'h00_0000, bus.status};
            default: readdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign write_go = avs_write & ~waitrequest_reg & avs_byteenable[0];
   assign sel = reg_sel(avs_address);
   assign bus.ctrl_wr = write_go & sel[0];
   assign bus.count_wr = write_go & sel[1];
   assign bus.wdata = avs_writedata[7:0];
   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;
endmodule

// ### hw/itc_timer.sv
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module itc_timer
   import itc_pkg::*;
#(
   parameter int AW = 4
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic [AW-1:0] avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output      logic [31:0]   avs_readdata,
   output      logic          avs_waitrequest,
   input  wire logic          count_clk,
   input  wire logic          gate,
   output      logic          timer_out
);
   itc_reg_if rb();

   itc_avalon_regs #(.AW(AW)) u_regs (
      .clk             (clk),
      .srst            (srst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .bus             (rb)
   );

   logic                cclk_meta_reg;
   logic                cclk_sync_reg;
   logic                cclk_prev_reg;
   logic                gate_meta_reg;
   logic                gate_sync_reg;
   logic                gate_prev_reg;
   logic                tick;
   logic                gate_rise;
   logic                trig_reg;
   logic [1:0]          rl_reg;
   logic [2:0]          mode_bits_reg;
   logic                bcd_reg;
   itc_mode_type        mode_reg;
   itc_mode_type        new_mode;
   logic [CNT_W-1:0]    cr_reg;
   logic                msb_wait_reg;
   logic                ctrl_cmd;
   logic                first_byte;
   logic                count_done;
   itc_phase_type       phase_reg;
   logic [CNT_W-1:0]    ce_reg;
   logic [CNT_W-1:0]    dec1;
   logic [CNT_W-1:0]    dec2;
   logic [CNT_W-1:0]    sq_load;
   logic [CNT_W-1:0]    sq_end;
   logic                sq_odd_reg;
   logic                out_reg;
   logic                null_reg;
   logic                armed_reg;
   logic                host_quiet;

   // pin inputs pass two flip-flops before anything looks at them
   always_ff @(posedge clk) begin
      if (srst) begin
         cclk_meta_reg <= 1'b0;
         cclk_sync_reg <= 1'b0;
         cclk_prev_reg <= 1'b0;
      end else begin
         cclk_meta_reg <= count_clk;
         cclk_sync_reg <= cclk_meta_reg;
         cclk_prev_reg <= cclk_sync_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gate_meta_reg <= 1'b0;
         gate_sync_reg <= 1'b0;
         gate_prev_reg <= 1'b0;
      end else begin
         gate_meta_reg <= gate;
         gate_sync_reg <= gate_meta_reg;
         gate_prev_reg <= gate_sync_reg;
      end
   end

   // counting happens on the falling edge of the count clock
   assign tick = cclk_prev_reg & ~cclk_sync_reg;
   assign gate_rise = gate_sync_reg & ~gate_prev_reg;

   // a trigger arriving on the consuming tick survives for the next one
   always_ff @(posedge clk) begin
      if (srst)
         trig_reg <= 1'b0;
      else if (gate_rise)
         trig_reg <= 1'b1;
      else if (tick || ctrl_cmd)
         trig_reg <= 1'b0;
   end

   // a control word with load format zero is a latch command; not served here
   assign ctrl_cmd = rb.ctrl_wr && (rb.wdata[CW_RL_LSB +: 2] != RL_LATCH);
   assign new_mode = itc_decode_mode(rb.wdata[CW_MODE_LSB +: 3]);
   assign first_byte = rb.count_wr && (rl_reg == RL_BOTH) && !msb_wait_reg;
   assign count_done = rb.count_wr && ((rl_reg != RL_BOTH) || msb_wait_reg);

   always_ff @(posedge clk) begin
      if (srst) begin
         rl_reg <= CW_RESET[CW_RL_LSB +: 2];
         mode_bits_reg <= CW_RESET[CW_MODE_LSB +: 3];
         bcd_reg <= CW_RESET[CW_BCD_BIT];
         mode_reg <= itc_decode_mode(CW_RESET[CW_MODE_LSB +: 3]);
      end else if (ctrl_cmd) begin
         rl_reg <= rb.wdata[CW_RL_LSB +: 2];
         mode_bits_reg <= rb.wdata[CW_MODE_LSB +: 3];
         bcd_reg <= rb.wdata[CW_BCD_BIT];
         mode_reg <= new_mode;
      end
   end

   // count holding register assembled per the load format
   always_ff @(posedge clk) begin
      if (srst) begin
         cr_reg <= CE_ZERO;
         msb_wait_reg <= 1'b0;
      end else if (ctrl_cmd) begin
         msb_wait_reg <= 1'b0;
      end else if (rb.count_wr) begin
         unique case (rl_reg)
            RL_LOW:  cr_reg <= {8'h00, rb.wdata};
            RL_HIGH: cr_reg <= {rb.wdata, 8'h00};
            RL_BOTH: begin
               if (msb_wait_reg)
                  cr_reg[15:8] <= rb.wdata;
               else
                  cr_reg[7:0] <= rb.wdata;
               msb_wait_reg <= ~msb_wait_reg;
            end
            default: ;
         endcase
      end
   end

   // zero wraps to all ones (or 9999), giving the full-range count
   assign dec1 = itc_dec1(ce_reg, bcd_reg);
   assign dec2 = itc_dec1(dec1, bcd_reg);
   assign sq_load = {cr_reg[CNT_W-1:1], 1'b0};
   assign sq_end = (sq_odd_reg && out_reg) ? CE_ZERO : CE_TWO;

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_reg <= PH_IDLE;
         ce_reg <= CE_ZERO;
         out_reg <= OUT_RESET;
         null_reg <= 1'b0;
         armed_reg <= 1'b0;
         sq_odd_reg <= 1'b0;
      end else if (ctrl_cmd) begin
         phase_reg <= PH_IDLE;
         ce_reg <= CE_ZERO;
         out_reg <= (new_mode != MODE_TERM);
         null_reg <= 1'b1;
         armed_reg <= 1'b0;
      end else if (first_byte && mode_reg == MODE_TERM) begin
         phase_reg <= PH_IDLE;
         out_reg <= 1'b0;
      end else begin
         if (tick) begin
            unique case (mode_reg)
               MODE_TERM: begin
                  if (phase_reg == PH_LOAD) begin
                     ce_reg <= cr_reg;
                     phase_reg <= PH_RUN;
                     null_reg <= 1'b0;
                  end else if (phase_reg == PH_RUN && gate_sync_reg) begin
                     ce_reg <= dec1;
                     if (dec1 == CE_ZERO)
                        out_reg <= 1'b1;
                  end
               end
               MODE_ONESHOT: begin
                  if (trig_reg && armed_reg) begin
                     ce_reg <= cr_reg;
                     out_reg <= 1'b0;
                     phase_reg <= PH_RUN;
                     null_reg <= 1'b0;
                  end else if (phase_reg == PH_RUN) begin
                     ce_reg <= dec1;
                     if (dec1 == CE_ZERO)
                        out_reg <= 1'b1;
                  end
               end
               MODE_RATE: begin
                  if (phase_reg == PH_LOAD || (trig_reg && armed_reg)) begin
                     ce_reg <= cr_reg;
                     out_reg <= 1'b1;
                     phase_reg <= PH_RUN;
                     null_reg <= 1'b0;
                  end else if (phase_reg == PH_RUN && gate_sync_reg) begin
                     if (ce_reg == CE_ONE) begin
                        ce_reg <= cr_reg;
                        out_reg <= 1'b1;
                        null_reg <= 1'b0;
                     end else begin
                        ce_reg <= dec1;
                        out_reg <= (dec1 != CE_ONE);
                     end
                  end
               end
               MODE_SQUARE: begin
                  if (phase_reg == PH_LOAD || (trig_reg && armed_reg)) begin
                     ce_reg <= sq_load;
                     sq_odd_reg <= cr_reg[0];
                     out_reg <= 1'b1;
                     phase_reg <= PH_RUN;
                     null_reg <= 1'b0;
                  end else if (phase_reg == PH_RUN && gate_sync_reg) begin
                     if (ce_reg == sq_end) begin
                        out_reg <= ~out_reg;
                        ce_reg <= sq_load;
                        sq_odd_reg <= cr_reg[0];
                        null_reg <= 1'b0;
                     end else begin
                        ce_reg <= dec2;
                     end
                  end
               end
               MODE_SWSTB: begin
                  if (phase_reg == PH_LOAD) begin
                     ce_reg <= cr_reg;
                     out_reg <= 1'b1;
                     phase_reg <= PH_RUN;
                     null_reg <= 1'b0;
                  end else if (phase_reg != PH_IDLE && gate_sync_reg) begin
                     ce_reg <= dec1;
                     if (phase_reg == PH_DONE) begin
                        out_reg <= 1'b1;
                     end else if (dec1 == CE_ZERO) begin
                        out_reg <= 1'b0;
                        phase_reg <= PH_DONE;
                     end
                  end else if (phase_reg == PH_DONE) begin
                     out_reg <= 1'b1;
                  end
               end
               MODE_HWSTB: begin
                  out_reg <= 1'b1;
               end
            endcase
         end
         if (count_done) begin
            null_reg <= 1'b1;
            armed_reg <= 1'b1;
            unique case (mode_reg)
               MODE_TERM: begin
                  phase_reg <= PH_LOAD;
                  out_reg <= 1'b0;
               end
               MODE_SWSTB: begin
                  phase_reg <= PH_LOAD;
               end
               MODE_RATE, MODE_SQUARE: begin
                  if (!armed_reg)
                     phase_reg <= PH_LOAD;
               end
               default: ;
            endcase
         end
         if ((mode_reg == MODE_RATE || mode_reg == MODE_SQUARE) && !gate_sync_reg)
            out_reg <= 1'b1;
      end
   end

   assign host_quiet = !rb.ctrl_wr && !rb.count_wr;
   assign timer_out = out_reg;
   assign rb.ctrl_word = {rl_reg, mode_bits_reg, bcd_reg};
   assign rb.ce_value = ce_reg;
   assign rb.status = {3'h0, phase_reg == PH_RUN, gate_sync_reg, msb_wait_reg,
                       null_reg, out_reg};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   term_low_a: assert property (
      ctrl_cmd && new_mode == MODE_TERM |=> !timer_out [*2])
      else $error("mode 0 output not low after control word");

   oneshot_high_a: assert property (
      ctrl_cmd && new_mode == MODE_ONESHOT |=> timer_out)
      else $error("mode 1 output not high after control word");

   term_gate_hold_a: assert property (
      mode_reg == MODE_TERM && phase_reg == PH_RUN && tick && !gate_sync_reg
      && host_quiet |=> $stable(ce_reg) && $stable(timer_out))
      else $error("mode 0 counted or changed output with gate low");

   load_nodec_a: assert property (
      (mode_reg == MODE_TERM || mode_reg == MODE_SWSTB) && phase_reg == PH_LOAD
      && tick && host_quiet |=> ce_reg == $past(cr_reg))
      else $error("count load tick decremented or missed");

   first_byte_a: assert property (
      mode_reg == MODE_TERM && first_byte && !rb.ctrl_wr
      |=> !timer_out && phase_reg == PH_IDLE)
      else $error("first byte did not suspend mode 0");

   zero_max_a: assert property (
      mode_reg == MODE_TERM && phase_reg == PH_RUN && tick && gate_sync_reg
      && !bcd_reg && ce_reg == CE_ZERO && host_quiet |=> ce_reg == 16'hffff)
      else $error("zero count did not wrap to full range");

   bcd_wrap_a: assert property (
      mode_reg == MODE_TERM && phase_reg == PH_RUN && tick && gate_sync_reg
      && bcd_reg && ce_reg == 16'h0100 && host_quiet |=> ce_reg == 16'h0099)
      else $error("decimal borrow wrong");

   oneshot_trig_a: assert property (
      mode_reg == MODE_ONESHOT && trig_reg && armed_reg && tick && host_quiet
      |=> !timer_out && ce_reg == $past(cr_reg))
      else $error("one-shot trigger did not load and drop output");

   rate_pulse_a: assert property (
      mode_reg == MODE_RATE && phase_reg == PH_RUN && tick && gate_sync_reg
      && ce_reg == CE_TWO && !trig_reg && host_quiet
      |=> !timer_out && ce_reg == CE_ONE)
      else $error("rate pulse missing at count one");

   gate_force_a: assert property (
      (mode_reg == MODE_RATE || mode_reg == MODE_SQUARE) && !gate_sync_reg
      && !ctrl_cmd |=> timer_out)
      else $error("gate low did not force output high");

   square_step_a: assert property (
      mode_reg == MODE_SQUARE && phase_reg == PH_RUN && tick && gate_sync_reg
      && !bcd_reg && ce_reg != sq_end && !trig_reg && host_quiet
      |=> ce_reg == $past(ce_reg) - CE_TWO)
      else $error("square mode did not step by two");

   strobe_end_a: assert property (
      mode_reg == MODE_SWSTB && !timer_out && tick && !ctrl_cmd |=> timer_out)
      else $error("strobe longer than one tick");

   term_reach_c: cover property (
      mode_reg == MODE_TERM && $rose(timer_out));
   square_flip_c: cover property (
      mode_reg == MODE_SQUARE && $fell(timer_out));
   strobe_seen_c: cover property (
      mode_reg == MODE_SWSTB && $fell(timer_out));
   oneshot_go_c: cover property (
      mode_reg == MODE_ONESHOT && $fell(timer_out));
endmodule

// ### bench/itc_cclk_model.sv
`timescale 1ns/100ps
module itc_cclk_model (
   input  wire logic clk,
   input  wire logic fire,
   output      logic count_clk
);
   logic [2:0] low_cnt_reg = 3'h0;

   // one low pulse of four clk per request; idle high, so each level lasts >= 3 clk
   always @(posedge clk) begin
      if (fire) begin
         low_cnt_reg <= 3'h4;
      end else if (low_cnt_reg != 3'h0) begin
         low_cnt_reg <= low_cnt_reg - 3'h1;
      end
   end

   assign count_clk = (low_cnt_reg == 3'h0);
endmodule

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import itc_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        count_clk;
   logic        gate = 1'b1;
   logic        timer_out;
   logic        fire = 1'b0;
   logic        smp = 1'b0;
   logic [31:0] q_rd[$];
   logic        q_out[$];
   int          errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          seed = 60;
   int          n;

   itc_timer #(.AW(4)) u_dut (.clk(clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .count_clk(count_clk), .gate(gate),
      .timer_out(timer_out));
   itc_cclk_model u_cclk (.clk(clk), .fire(fire), .count_clk(count_clk));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic summarize;
      if (errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cmp_out(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t out %h exp %h", $time, got, exp);
      end
   endtask

   // request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      q_rd.push_back(exp);
      bus(1'b0, a, 8'h00);
   endtask

   task automatic chk(input logic exp);
      q_out.push_back(exp);
      smp <= 1'b1;
      @(posedge clk);
      smp <= 1'b0;
   endtask

   task automatic tick(input logic exp);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (10) @(posedge clk);
      chk(exp);
   endtask

   // output low where (tick index mod per) lies in [lo, hi)
   task automatic run(input int k, input int lo, input int hi, input int per);
      for (int i = 0; i < k; i++) begin
         tick(!((i % per) >= lo && (i % per) < hi));
      end
   endtask

   task automatic settle;
      repeat (5) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (avs_read && avs_waitrequest === 1'b0) begin
         cmp_rd(avs_readdata, q_rd.pop_front());
      end
      if (smp) begin
         cmp_out(timer_out, q_out.pop_front());
      end
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'hc, 32'h0);
      n = 1 + ($random(seed) & 7);
      bus(1'b1, 4'h0, 8'h10);
      chk(1'b0);
      bus(1'b1, 4'h4, n[7:0]);
      run(n + 3, 0, n, 1000);
      bus(1'b1, 4'h0, 8'h30);
      bus(1'b1, 4'h4, 8'h01);
      bus(1'b1, 4'h4, 8'h00);
      run(3, 0, 1, 1000);
      bus(1'b1, 4'h4, 8'h02);
      chk(1'b0);
      bus(1'b1, 4'h4, 8'h00);
      run(4, 0, 2, 1000);
      gate <= 1'b0;
      bus(1'b1, 4'h0, 8'h10);
      bus(1'b1, 4'h4, 8'h02);
      run(3, 0, 3, 1000);
      gate <= 1'b1;
      settle();
      run(3, 0, 1, 1000);
      gate <= 1'b0;
      bus(1'b1, 4'h0, 8'h12);
      chk(1'b1);
      bus(1'b1, 4'h4, 8'h02);
      settle();
      gate <= 1'b1;
      settle();
      run(4, 0, 2, 1000);
      gate <= 1'b0;
      settle();
      gate <= 1'b1;
      settle();
      run(1, 0, 1, 1000);
      bus(1'b1, 4'h4, 8'h03);
      run(2, 0, 1, 1000);
      gate <= 1'b0;
      settle();
      gate <= 1'b1;
      settle();
      run(4, 0, 3, 1000);
      bus(1'b1, 4'h0, 8'h1c);
      chk(1'b1);
      bus(1'b1, 4'h4, 8'h03);
      run(7, 2, 3, 3);
      bus(1'b1, 4'h0, 8'h16);
      bus(1'b1, 4'h4, 8'h05);
      run(10, 3, 5, 5);
      bus(1'b1, 4'h0, 8'h1e);
      bus(1'b1, 4'h4, 8'h04);
      run(8, 2, 4, 4);
      bus(1'b1, 4'h0, 8'h18);
      chk(1'b1);
      bus(1'b1, 4'h4, 8'h02);
      run(5, 2, 3, 1000);
      bus(1'b1, 4'h0, 8'h11);
      bus(1'b1, 4'h4, 8'h10);
      run(2, 0, 2, 1000);
      rd(4'h4, 32'h9);
      rd(4'h0, 32'h11);
      summarize();
   end
endmodule
